// ===== logic/led_bank_consts.vh
// Constants of the indicator pin register block: register indices,
// reset values and the start-up capture delay.
// Assumes a Wishbone byte address of four times the register index.
`ifndef LED_BANK_CONSTS_VH
`define LED_BANK_CONSTS_VH

// Register indices; the byte address is four times the index
`define IDX_B1_UPPER_LEVEL 16'hFF3B
`define IDX_B1_LOWER_MASK 16'hFF3C
`define IDX_B1_UPPER_MASK 16'hFF3D
`define IDX_B1_LOWER_CAPTURE 16'hFF3E
`define IDX_B1_UPPER_CAPTURE 16'hFF3F
`define IDX_B2_LOWER_CODES 16'hFF40
`define IDX_B2_UPPER_CODES 16'hFF41
`define IDX_B2_LOWER_LEVEL 16'hFF42
`define IDX_B2_UPPER_LEVEL 16'hFF43
`define IDX_B2_LOWER_MASK 16'hFF44
`define IDX_B2_UPPER_MASK 16'hFF45
`define IDX_B2_LOWER_CAPTURE 16'hFF46
`define IDX_B2_UPPER_CAPTURE 16'hFF47

// Reset values
`define RST_CODES 8'h00
`define RST_MASK 4'h0
`define RST_CAPTURE 4'h0

// Two-bit LED codes
`define CODE_OFF 2'h0
`define CODE_SLOW 2'h1
`define CODE_FAST 2'h2
`define CODE_ON 2'h3

// Edges after reset release before synchronised pins are valid
`define CAPTURE_DELAY 2'h2

`endif

// ===== logic/led_pin_sync.v
// Two-flop synchroniser for the sixteen indicator pin levels.
// Assumes pins are asynchronous to REF_CLK.
`timescale 1ns/100ps
module led_pin_sync (
  input wire clk,
  input wire rst_n,
  input wire [15:0] pins_async,
  output reg [15:0] pins_sync
);

  reg [15:0] meta_q;

  // First stage feeds only the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 16'h0000;
      pins_sync <= 16'h0000;
    end else begin
      meta_q <= pins_async;
      pins_sync <= meta_q;
    end
  end

endmodule

// ===== logic/led_code_driver.v
// Open-drain driver control for eight LED pins from two-bit codes.
// Assumes blink phases come from the shared blink generator on clk.
`timescale 1ns/100ps
`include "led_bank_consts.vh"
module led_code_driver (
  input wire clk,
  input wire rst_n,
  input wire [15:0] codes,
  input wire slow_phase,
  input wire fast_phase,
  output reg [7:0] drive_low
);

  reg [7:0] drive_d;
  integer i;

  // Decode each pin's code; off releases the driver entirely
  always @* begin
    drive_d = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      case (codes[2*i +: 2])
        `CODE_OFF: drive_d[i] = 1'b0;
        `CODE_SLOW: drive_d[i] = slow_phase;
        `CODE_FAST: drive_d[i] = fast_phase;
        `CODE_ON: drive_d[i] = 1'b1;
        default: drive_d[i] = 1'b0;
      endcase
    end
  end

  // Registered so the pin enables never glitch on code writes
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_low <= 8'h00;
    end else begin
      drive_low <= drive_d;
    end
  end

endmodule

// ===== logic/led_bank_pin_registers.v
// Register block for indicator pin banks 1 and 2: live pin levels except bank 1 lower,
// power-on captures with write masks, and bank 2 LED mode codes.
// Assumes a classic Wishbone master on REF_CLK, pins asynchronous,
// and blink phases from the shared blink generator on REF_CLK.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/100ps
`include "led_bank_consts.vh"

module led_bank_pin_registers (
  input wire REF_CLK,
  input wire RSTN,
  input wire [17:0] ADR_I,
  input wire [31:0] DAT_I,
  output reg [31:0] DAT_O,
  input wire WE_I,
  input wire [3:0] SEL_I,
  input wire CYC_I,
  input wire STB_I,
  output reg ACK_O,
  input wire BLINK_SLOW,
  input wire BLINK_FAST,
  input wire [7:0] INDICATOR_PINS_BANK1_I,
  input wire [7:0] INDICATOR_PINS_BANK2_I,
  output wire [7:0] INDICATOR_PINS_BANK2_O,
  output wire [7:0] INDICATOR_PINS_BANK2_OE
);

  // Place four pin bits on the even positions, odd ones zero
  function [7:0] spread;
    input [3:0] n;
    begin
      spread = {1'b0, n[3], 1'b0, n[2], 1'b0, n[1], 1'b0, n[0]};
    end
  endfunction

  // Pick the four even bits of a written byte
  function [3:0] gather;
    input [7:0] d;
    begin
      gather = {d[6], d[4], d[2], d[0]};
    end
  endfunction

  // Masked update: only bits with mask 1 take the new value
  function [3:0] merge;
    input [3:0] old;
    input [3:0] nw;
    input [3:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  // Synchronised pins: [7:0] bank 1, [15:8] bank 2
  wire [15:0] pins_sync;
  wire [3:0] b1_lo_level;
  wire [3:0] b1_hi_level;
  wire [3:0] b2_lo_level;
  wire [3:0] b2_hi_level;
  wire [7:0] b2_drive_low;

  // Stored state
  reg [7:0] b2_lo_codes_q;
  reg [7:0] b2_hi_codes_q;
  reg [3:0] b1_lo_mask_q;
  reg [3:0] b1_hi_mask_q;
  reg [3:0] b2_lo_mask_q;
  reg [3:0] b2_hi_mask_q;
  reg [3:0] b1_lo_cap_q;
  reg [3:0] b1_hi_cap_q;
  reg [3:0] b2_lo_cap_q;
  reg [3:0] b2_hi_cap_q;
  reg [1:0] cap_cnt_q;
  reg cap_done_q;

  // Bus decode
  wire [15:0] idx;
  wire req;
  wire wr;
  wire [3:0] wnib;
  reg [31:0] rd_d;

  led_pin_sync u_sync (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .pins_async({INDICATOR_PINS_BANK2_I, INDICATOR_PINS_BANK1_I}),
    .pins_sync(pins_sync)
  );

  // Live levels follow the pin whatever its code, so a released
  // pin doubles as an input
  assign b1_lo_level = pins_sync[3:0];
  assign b1_hi_level = pins_sync[7:4];
  assign b2_lo_level = pins_sync[11:8];
  assign b2_hi_level = pins_sync[15:12];

  led_code_driver u_drive (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .codes({b2_hi_codes_q, b2_lo_codes_q}),
    .slow_phase(BLINK_SLOW),
    .fast_phase(BLINK_FAST),
    .drive_low(b2_drive_low)
  );

  // Open drain: the pin is only ever pulled low, enable marks driving
  assign INDICATOR_PINS_BANK2_O = 8'h00;
  assign INDICATOR_PINS_BANK2_OE = b2_drive_low;

  // Requests wait for the start-up capture, so a write cannot race it
  assign idx = ADR_I[17:2];
  assign req = CYC_I & STB_I & ~ACK_O & cap_done_q;
  assign wr = req & WE_I & SEL_I[0];
  assign wnib = gather(DAT_I[7:0]);

  // Start-up capture: wait until the synchroniser holds post-reset pins
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cap_cnt_q <= 2'h0;
      cap_done_q <= 1'b0;
    end else if (!cap_done_q) begin
      if (cap_cnt_q == `CAPTURE_DELAY) begin
        cap_done_q <= 1'b1;
      end else begin
        cap_cnt_q <= cap_cnt_q + 2'h1;
      end
    end
  end

  // Mode code registers, full byte wide
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      b2_lo_codes_q <= `RST_CODES;
      b2_hi_codes_q <= `RST_CODES;
    end else if (wr) begin
      if (idx == `IDX_B2_LOWER_CODES) begin
        b2_lo_codes_q <= DAT_I[7:0];
      end
      if (idx == `IDX_B2_UPPER_CODES) begin
        b2_hi_codes_q <= DAT_I[7:0];
      end
    end
  end

  // Write masks keep only the even bits
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      b1_lo_mask_q <= `RST_MASK;
      b1_hi_mask_q <= `RST_MASK;
      b2_lo_mask_q <= `RST_MASK;
      b2_hi_mask_q <= `RST_MASK;
    end else if (wr) begin
      if (idx == `IDX_B1_LOWER_MASK) begin
        b1_lo_mask_q <= wnib;
      end
      if (idx == `IDX_B1_UPPER_MASK) begin
        b1_hi_mask_q <= wnib;
      end
      if (idx == `IDX_B2_LOWER_MASK) begin
        b2_lo_mask_q <= wnib;
      end
      if (idx == `IDX_B2_UPPER_MASK) begin
        b2_hi_mask_q <= wnib;
      end
    end
  end

  // Capture registers: loaded once after reset release, then
  // writable only through their masks
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      b1_lo_cap_q <= `RST_CAPTURE;
      b1_hi_cap_q <= `RST_CAPTURE;
      b2_lo_cap_q <= `RST_CAPTURE;
      b2_hi_cap_q <= `RST_CAPTURE;
    end else if (!cap_done_q) begin
      if (cap_cnt_q == `CAPTURE_DELAY) begin
        b1_lo_cap_q <= b1_lo_level;
        b1_hi_cap_q <= b1_hi_level;
        b2_lo_cap_q <= b2_lo_level;
        b2_hi_cap_q <= b2_hi_level;
      end
    end else if (wr) begin
      if (idx == `IDX_B1_LOWER_CAPTURE) begin
        b1_lo_cap_q <= merge(b1_lo_cap_q, wnib, b1_lo_mask_q);
      end
      if (idx == `IDX_B1_UPPER_CAPTURE) begin
        b1_hi_cap_q <= merge(b1_hi_cap_q, wnib, b1_hi_mask_q);
      end
      if (idx == `IDX_B2_LOWER_CAPTURE) begin
        b2_lo_cap_q <= merge(b2_lo_cap_q, wnib, b2_lo_mask_q);
      end
      if (idx == `IDX_B2_UPPER_CAPTURE) begin
        b2_hi_cap_q <= merge(b2_hi_cap_q, wnib, b2_hi_mask_q);
      end
    end
  end

  // Read multiplexer; unmapped indices read zero
  always @* begin
    rd_d = 32'h00000000;
    case (idx)
      `IDX_B1_UPPER_LEVEL: rd_d[7:0] = spread(b1_hi_level);
      `IDX_B1_LOWER_MASK: rd_d[7:0] = spread(b1_lo_mask_q);
      `IDX_B1_UPPER_MASK: rd_d[7:0] = spread(b1_hi_mask_q);
      `IDX_B1_LOWER_CAPTURE: rd_d[7:0] = spread(b1_lo_cap_q);
      `IDX_B1_UPPER_CAPTURE: rd_d[7:0] = spread(b1_hi_cap_q);
      `IDX_B2_LOWER_CODES: rd_d[7:0] = b2_lo_codes_q;
      `IDX_B2_UPPER_CODES: rd_d[7:0] = b2_hi_codes_q;
      `IDX_B2_LOWER_LEVEL: rd_d[7:0] = spread(b2_lo_level);
      `IDX_B2_UPPER_LEVEL: rd_d[7:0] = spread(b2_hi_level);
      `IDX_B2_LOWER_MASK: rd_d[7:0] = spread(b2_lo_mask_q);
      `IDX_B2_UPPER_MASK: rd_d[7:0] = spread(b2_hi_mask_q);
      `IDX_B2_LOWER_CAPTURE: rd_d[7:0] = spread(b2_lo_cap_q);
      `IDX_B2_UPPER_CAPTURE: rd_d[7:0] = spread(b2_hi_cap_q);
      default: rd_d = 32'h00000000;
    endcase
  end

  // One-cycle acknowledge with registered read data; every address
  // answers so a stray access never hangs the master
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h00000000;
    end else begin
      ACK_O <= req;
      if (req) begin
        DAT_O <= rd_d;
      end
    end
  end

endmodule

// ===== verification/led_pin_partner.sv
// Open-drain LED wires of bank 2 with their pull-ups.
// Assumes another device may also pull a wire low.
`timescale 1ns/100ps
module led_pin_partner (
  input logic [7:0] oe,
  input logic [7:0] o,
  input logic [7:0] ext_low,
  output logic [7:0] level
);
  // A released wire shows the pull-up unless the far device sinks it
  assign level = (oe & o) | (~oe & ~ext_low);
endmodule

// ===== verification/led_bank_pin_registers_asserts.sv
// Checker for the indicator pin register block.
// Assumes one clock domain and acked classic bus cycles.
`timescale 1ns/100ps
module led_bank_pin_registers_asserts (
  input logic REF_CLK,
  input logic RSTN,
  input logic [17:0] ADR_I,
  input logic [31:0] DAT_I,
  input logic [31:0] DAT_O,
  input logic WE_I,
  input logic [3:0] SEL_I,
  input logic CYC_I,
  input logic STB_I,
  input logic ACK_O,
  input logic BLINK_SLOW,
  input logic BLINK_FAST,
  input logic [7:0] INDICATOR_PINS_BANK2_I,
  input logic [7:0] INDICATOR_PINS_BANK2_OE
);
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);
  // Acked cycle decode; the master still holds its request here
  wire [15:0] idx = ADR_I[17:2];
  wire wr = ACK_O && WE_I && SEL_I[0];
  wire rd = ACK_O && !WE_I;
  wire [7:0] oe = INDICATOR_PINS_BANK2_OE;
  wire [7:0] pin = INDICATOR_PINS_BANK2_I;
  property p_ack_pulse; ACK_O |=> !ACK_O; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
  property p_ack_cause; ACK_O |-> $past(CYC_I && STB_I); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_start; $rose(RSTN) |-> (!ACK_O && oe == 8'h00) [*3]; endproperty
  a_start: assert property (p_start) else $error("early ack or lit pin after reset");
  property p_off; wr && idx == 16'hFF40 && DAT_I[1:0] == 2'h0 |=> !oe[0]; endproperty
  a_off: assert property (p_off) else $error("off code still drives");
  property p_slow; wr && idx == 16'hFF40 && DAT_I[3:2] == 2'h1 |=> oe[1] == $past(BLINK_SLOW); endproperty
  a_slow: assert property (p_slow) else $error("slow code not on slow phase");
  property p_fast; wr && idx == 16'hFF41 && DAT_I[5:4] == 2'h2 |=> oe[6] == $past(BLINK_FAST); endproperty
  a_fast: assert property (p_fast) else $error("fast code not on fast phase");
  property p_on; wr && idx == 16'hFF41 && DAT_I[7:6] == 2'h3 |=> oe[7]; endproperty
  a_on: assert property (p_on) else $error("on code not driving");
  property p_odd;
    rd && (idx inside {[16'hFF3B:16'hFF3F], [16'hFF42:16'hFF47]}) |-> (DAT_O & 32'hFFFFFFAA) == 32'h0;
  endproperty
  a_odd: assert property (p_odd) else $error("odd bit set in read");
  property p_level;
    rd && idx == 16'hFF42 && $past(pin) == pin && $past(pin, 2) == pin && $past(pin, 3) == pin
      |-> {DAT_O[6], DAT_O[4], DAT_O[2], DAT_O[0]} == pin[3:0];
  endproperty
  a_level: assert property (p_level) else $error("level read differs from pins");
  c_codes: cover property (wr && idx == 16'hFF41);
  c_level: cover property (rd && idx == 16'hFF42);
  c_restart: cover property ($rose(RSTN));
endmodule

bind led_bank_pin_registers led_bank_pin_registers_asserts i_chk (.REF_CLK(REF_CLK), .RSTN(RSTN),
  .ADR_I(ADR_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .WE_I(WE_I), .SEL_I(SEL_I), .CYC_I(CYC_I),
  .STB_I(STB_I), .ACK_O(ACK_O), .BLINK_SLOW(BLINK_SLOW), .BLINK_FAST(BLINK_FAST),
  .INDICATOR_PINS_BANK2_I(INDICATOR_PINS_BANK2_I), .INDICATOR_PINS_BANK2_OE(INDICATOR_PINS_BANK2_OE));

// ===== verification/led_bank_pin_registers_bench.sv
// Self-checking bench of the indicator pin register block.
// Assumes the pin partner model and the bound checker.
`timescale 1ns/100ps
module led_bank_pin_registers_bench;
  logic REF_CLK = 1'h0, RSTN = 1'h0, WE_I = 1'h0, CYC_I = 1'h0, STB_I = 1'h0;
  logic BLINK_SLOW = 1'h1, BLINK_FAST = 1'h0;
  logic [17:0] ADR_I = 18'h0;
  logic [31:0] DAT_I = 32'h0;
  logic [3:0] SEL_I = 4'h1;
  logic [7:0] INDICATOR_PINS_BANK1_I = 8'h3C, ext_low = 8'hA5, q;
  wire [31:0] DAT_O;
  wire ACK_O;
  wire [7:0] INDICATOR_PINS_BANK2_I, INDICATOR_PINS_BANK2_O, INDICATOR_PINS_BANK2_OE;
  int bad_count = 0, n_checks = 0;
  // Rows: {write, register index, write data or expected read}
  logic [24:0] rows [31] = '{25'h0FF3B05, 25'h0FF4255, 25'h0FF4355, 25'h0FF3E50, 25'h0FF3F05,
    25'h0FF4644, 25'h0FF4711, 25'h0FF3C00, 25'h0FF3D00, 25'h0FF4400, 25'h0FF4500, 25'h0FF4000,
    25'h0FF4100, 25'h0000000, 25'h1FF4600, 25'h0FF4644, 25'h1FF44FF, 25'h0FF4455, 25'h1FF460F,
    25'h0FF4605, 25'h1FF4504, 25'h1FF47FF, 25'h0FF4715, 25'h1FF42FF, 25'h0FF4255, 25'h1FF40E4,
    25'h1FF41E4, 25'h0FF40E4, 25'h0FF41E4, 25'h0FF4211, 25'h0FF4311};
  led_bank_pin_registers i_dut (.REF_CLK(REF_CLK), .RSTN(RSTN), .ADR_I(ADR_I), .DAT_I(DAT_I),
    .DAT_O(DAT_O), .WE_I(WE_I), .SEL_I(SEL_I), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O),
    .BLINK_SLOW(BLINK_SLOW), .BLINK_FAST(BLINK_FAST), .INDICATOR_PINS_BANK1_I(INDICATOR_PINS_BANK1_I),
    .INDICATOR_PINS_BANK2_I(INDICATOR_PINS_BANK2_I), .INDICATOR_PINS_BANK2_O(INDICATOR_PINS_BANK2_O),
    .INDICATOR_PINS_BANK2_OE(INDICATOR_PINS_BANK2_OE));
  led_pin_partner i_pins (.oe(INDICATOR_PINS_BANK2_OE), .o(INDICATOR_PINS_BANK2_O), .ext_low(ext_low),
    .level(INDICATOR_PINS_BANK2_I));
  // 20 MHz clock
  always #25 REF_CLK = ~REF_CLK;
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // One classic cycle; idles three cycles so pin changes reach the level flops
  task bus(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] r);
    int n;
    CYC_I <= 1'h1;
    STB_I <= 1'h1;
    WE_I <= w;
    ADR_I <= {a, 2'h0};
    DAT_I <= {24'h0, d};
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (ACK_O !== 1'h1 && n < 20);
    if (ACK_O !== 1'h1) begin
      chk("ack", 8'h1, 8'h0);
      conclude();
    end
    r = DAT_O[7:0];
    CYC_I <= 1'h0;
    STB_I <= 1'h0;
    repeat (3) @(posedge REF_CLK);
  endtask
  initial begin
    repeat (16) @(posedge REF_CLK);
    RSTN <= 1'h1;
    repeat (4) @(posedge REF_CLK);
    ext_low <= 8'h00;
    repeat (4) @(posedge REF_CLK);
    foreach (rows[i]) begin
      bus(rows[i][24], rows[i][23:8], rows[i][7:0], q);
      if (!rows[i][24]) chk($sformatf("reg %h", rows[i][23:8]), rows[i][7:0], q);
    end
    // Blink pins must follow the shared phases, not the codes
    chk("oe slow phase", 8'hAA, INDICATOR_PINS_BANK2_OE);
    chk("pin out level", 8'h00, INDICATOR_PINS_BANK2_O);
    BLINK_SLOW <= 1'h0;
    BLINK_FAST <= 1'h1;
    repeat (3) @(posedge REF_CLK);
    chk("oe fast phase", 8'hCC, INDICATOR_PINS_BANK2_OE);
    // Second reset: captures reload, codes clear
    ext_low <= 8'h0F;
    RSTN <= 1'h0;
    repeat (4) @(posedge REF_CLK);
    chk("oe in reset", 8'h00, INDICATOR_PINS_BANK2_OE);
    RSTN <= 1'h1;
    repeat (4) @(posedge REF_CLK);
    bus(1'h0, 16'hFF47, 8'h00, q);
    chk("upper capture", 8'h55, q);
    bus(1'h0, 16'hFF46, 8'h00, q);
    chk("lower capture", 8'h00, q);
    // Bank 1 masks gate their own captures; odd bits of a write are dropped
    bus(1'h1, 16'hFF3C, 8'hC3, q);
    bus(1'h0, 16'hFF3C, 8'h00, q);
    chk("bank1 lower mask", 8'h41, q);
    bus(1'h1, 16'hFF3E, 8'h00, q);
    bus(1'h0, 16'hFF3E, 8'h00, q);
    chk("bank1 lower capture", 8'h10, q);
    bus(1'h1, 16'hFF3D, 8'hFF, q);
    bus(1'h1, 16'hFF3F, 8'hAA, q);
    bus(1'h0, 16'hFF3F, 8'h00, q);
    chk("bank1 upper capture", 8'h00, q);
    // A write without its low byte lane selected leaves the codes alone
    SEL_I <= 4'h0;
    bus(1'h1, 16'hFF40, 8'hFF, q);
    SEL_I <= 4'h1;
    bus(1'h0, 16'hFF40, 8'h00, q);
    chk("unselected write", 8'h00, q);
    conclude();
  end
endmodule
